// ### rtl/role_resolve.sv
// Purpose: Fills the role exchange pages and resolves leader/follower role
// Assumes: Negotiation arbitration sits on sys_clk and drives the event pulses
// Notes:   Registers reached over an AXI4-Lite slave; no interrupt output
// Function
// - Exchange base, message, two unformatted pages in order
// - Ignore second acknowledge bit of received pages
// - Base page next-page bit set, rest advertised
// - Message page code field holds eight
// - Upper six bits of unformatted page zero
// - Duplex bits and port type from control
// - Forced role value and enable bits
// - Second unformatted page carries eleven-bit seed
// - Classify each side's type from page one
// - Resolve at good-check entry, gigabit only
// - Forced and port-type priorities decide role
// - Equal unforced types: larger seed leads
// - Equal seeds fail link, send new seed
// - Both forced alike: fault, complete, fail
// - Restart only after inhibit timer expiry
// - Seed counter cleared at start, counts seeds
// - Completion clears seed counter and fault
// - Seven seeds without resolution raise fault
// - Success reports role in status and indication
// - Seeds uniform from zero, uncorrelated, implementer's method
// - Fault latches, clears on read and events
`timescale 1ns/10ps
module role_resolve
  import role_res_pkg::*;
(
  input  wire  logic        sys_clk,
  input  wire  logic        reset,
  // AXI4-Lite slave
  input  wire  logic [7:0]  s_axi_awaddr,
  input  wire  logic        s_axi_awvalid,
  output logic              s_axi_awready,
  input  wire  logic [31:0] s_axi_wdata,
  input  wire  logic [3:0]  s_axi_wstrb,
  input  wire  logic        s_axi_wvalid,
  output logic              s_axi_wready,
  output logic [1:0]        s_axi_bresp,
  output logic              s_axi_bvalid,
  input  wire  logic        s_axi_bready,
  input  wire  logic [7:0]  s_axi_araddr,
  input  wire  logic        s_axi_arvalid,
  output logic              s_axi_arready,
  output logic [31:0]       s_axi_rdata,
  output logic [1:0]        s_axi_rresp,
  output logic              s_axi_rvalid,
  input  wire  logic        s_axi_rready,
  // Negotiation arbitration side
  input  wire  logic        neg_cycle_start,
  input  wire  logic        pulse_link_good_check_state,
  input  wire  logic        highest_common_technology,
  input  wire  logic        inhibit_expired,
  input  wire  logic        neg_enable_evt,
  input  wire  logic        neg_complete_evt,
  input  wire  logic        attach_reset,
  input  wire  logic [1:0]  tx_page_sel,
  output logic [15:0]       tx_page,
  input  wire  page_s       rx_page,
  output logic              copper_link_state,
  output logic              restart_req,
  output role_s             role_result_indication
);

  logic [4:0]  ctrl_r;
  logic [14:0] adv_r;
  logic [10:0] lfsr_r;
  logic [10:0] seed_r;
  logic [3:0]  seed_cnt_r;
  logic        seed_due_r;
  logic [15:0] rem_unf1_r;
  logic [10:0] rem_seed_r;
  logic [1:0]  exp_idx_r;
  logic        pages_ok_r;
  logic        seq_err_r;
  logic        fault_r;
  logic        link_fail_r;
  role_s       role_r;
  logic [15:0] tx_page_r;
  res_state_e  state_r;
  res_state_e  state_nxt;

  // Bus holding registers
  logic        aw_held_r;
  logic        w_held_r;
  logic [7:0]  awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;
  logic        bvalid_r;
  logic [1:0]  bresp_r;
  logic        rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0]  rresp_r;

  // Resolution terms
  dev_type_e   loc_type;
  dev_type_e   rem_type;
  logic        resolve_now;
  logic        forced_clash;
  logic        seed_tie;
  logic        loc_leads;
  logic        wr_fire;
  logic        rd_fire;
  logic        status_read;
  logic        seed_gen;
  logic [31:0] status_word;

  // Type from unformatted page one bits 2..0
  function automatic dev_type_e classify(input logic [2:0] u);
    dev_type_e t;
    t = TY_SINGLE;
    if (u[0]) begin
      t = u[1] ? TY_FLEAD : TY_FFOLL;
    end else if (u[2]) begin
      t = TY_MULTI;
    end
    return t;
  endfunction : classify

  // Bus slave
  assign s_axi_awready = !aw_held_r && !bvalid_r;
  assign s_axi_wready  = !w_held_r && !bvalid_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;

  assign wr_fire     = aw_held_r && w_held_r && !bvalid_r;
  assign rd_fire     = s_axi_arvalid && !rvalid_r;
  assign status_read = rd_fire && (s_axi_araddr == STATUS_OFS);

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      aw_held_r <= 1'b0;
      w_held_r  <= 1'b0;
      awaddr_r  <= 8'h00;
      wdata_r   <= 32'h0000_0000;
      wstrb_r   <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_r <= 1'b1;
        awaddr_r  <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_held_r <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_r <= 1'b1;
        wdata_r  <= s_axi_wdata;
        wstrb_r  <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_held_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      bvalid_r <= 1'b0;
      bresp_r  <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_r <= 1'b1;
      bresp_r  <= (awaddr_r == CTRL_OFS || awaddr_r == ADV_OFS) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // Writable registers; byte lanes honoured
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ctrl_r <= CTRL_RESET;
      adv_r  <= ADV_RESET;
    end else if (wr_fire) begin
      if (awaddr_r == CTRL_OFS && wstrb_r[0]) begin
        ctrl_r <= wdata_r[4:0];
      end
      if (awaddr_r == ADV_OFS) begin
        if (wstrb_r[0]) begin
          adv_r[7:0] <= wdata_r[7:0];
        end
        if (wstrb_r[1]) begin
          adv_r[14:8] <= wdata_r[14:8];
        end
      end
    end
  end

  always_comb begin
    status_word                = 32'h0000_0000;
    status_word[FAULT_POS]     = fault_r;
    status_word[ROLE_POS]      = role_r.leader;
    status_word[VALID_POS]     = role_r.valid;
    status_word[LFAIL_POS]     = link_fail_r;
    status_word[SEQERR_POS]    = seq_err_r;
    status_word[CNT_POS +: 4]  = seed_cnt_r;
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0000_0000;
      rresp_r  <= RESP_OKAY;
    end else if (rd_fire) begin
      rvalid_r <= 1'b1;
      rresp_r  <= RESP_OKAY;
      case (s_axi_araddr)
        CTRL_OFS:    rdata_r <= {27'h0, ctrl_r};
        STATUS_OFS:  rdata_r <= status_word;
        SEED_OFS:    rdata_r <= {21'h0, seed_r};
        ADV_OFS:     rdata_r <= {17'h0, adv_r};
        PARTNER_OFS: rdata_r <= {5'h0, rem_seed_r, rem_unf1_r};
        default: begin
          rdata_r <= 32'h0000_0000;
          rresp_r <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // Outgoing pages
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      tx_page_r <= 16'h0000;
    end else begin
      case (tx_page_sel)
        PG_BASE: tx_page_r <= {1'b1, adv_r};
        PG_MSG:  tx_page_r <= {5'h00, MSG_CODE_ROLE};
        PG_UNF1: tx_page_r <= {5'h00, 6'h00,
                               ctrl_r[HALF_POS], ctrl_r[FULL_POS], ctrl_r[PORT_POS],
                               ctrl_r[FORCE_VAL_POS], ctrl_r[FORCE_EN_POS]};
        PG_UNF2: tx_page_r <= {5'h00, seed_r};
        default: tx_page_r <= 16'h0000;
      endcase
    end
  end
  assign tx_page = tx_page_r;

  // Received pages must arrive in order; the code field, all of page one and the low seed bits are read
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      exp_idx_r  <= PG_BASE;
      pages_ok_r <= 1'b0;
      seq_err_r  <= 1'b0;
      rem_unf1_r <= 16'h0000;
      rem_seed_r <= 11'h000;
    end else if (neg_cycle_start) begin
      exp_idx_r  <= PG_BASE;
      pages_ok_r <= 1'b0;
      seq_err_r  <= 1'b0;
    end else if (rx_page.valid) begin
      if (rx_page.idx != exp_idx_r || pages_ok_r ||
          (rx_page.idx == PG_MSG && rx_page.bits[10:0] != MSG_CODE_ROLE)) begin
        seq_err_r <= 1'b1;
      end else begin
        exp_idx_r <= exp_idx_r + 2'h1;
        if (rx_page.idx == PG_UNF1) begin
          rem_unf1_r <= rx_page.bits;
        end
        if (rx_page.idx == PG_UNF2) begin
          rem_seed_r <= rx_page.bits[10:0];
          pages_ok_r <= 1'b1;
        end
      end
    end
  end

  // Free-running generator; nonzero values less one give 0..2046
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      lfsr_r <= LFSR_RESET;
    end else begin
      lfsr_r <= {lfsr_r[9:0], lfsr_r[10] ^ lfsr_r[8]};
    end
  end

  assign seed_gen = seed_due_r && (state_r == ST_IDLE || neg_cycle_start);

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      seed_r     <= 11'h000;
      seed_due_r <= 1'b1;
    end else if (seed_gen) begin
      seed_r     <= lfsr_r - 11'h001;
      seed_due_r <= 1'b0;
    end else if (resolve_now && seed_tie && seed_cnt_r < SEED_LIMIT) begin
      seed_due_r <= 1'b1;
    end
  end

  // Resolution
  assign loc_type     = classify(ctrl_r[2:0]);
  assign rem_type     = classify(rem_unf1_r[2:0]);
  assign resolve_now  = (state_r == ST_XCHG) && pulse_link_good_check_state &&
                        highest_common_technology && pages_ok_r && !seq_err_r;
  assign forced_clash = (loc_type == rem_type) &&
                        (loc_type == TY_FLEAD || loc_type == TY_FFOLL);
  assign seed_tie     = (loc_type == rem_type) && !forced_clash && (seed_r == rem_seed_r);

  always_comb begin
    loc_leads = 1'b0;
    case (loc_type)
      TY_FLEAD:  loc_leads = 1'b1;
      TY_FFOLL:  loc_leads = 1'b0;
      TY_MULTI:  loc_leads = (rem_type == TY_SINGLE) || (rem_type == TY_FFOLL) ||
                             (rem_type == TY_MULTI && seed_r > rem_seed_r);
      TY_SINGLE: loc_leads = (rem_type == TY_FFOLL) ||
                             (rem_type == TY_SINGLE && seed_r > rem_seed_r);
      default:   loc_leads = 1'b0;
    endcase
  end

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (neg_cycle_start) begin
          state_nxt = ST_XCHG;
        end
      end
      ST_XCHG: begin
        if (pulse_link_good_check_state) begin
          if (!highest_common_technology) begin
            state_nxt = ST_GOOD;
          end else if (!pages_ok_r || seq_err_r) begin
            state_nxt = ST_FAIL;
          end else if (forced_clash || (seed_tie && seed_cnt_r >= SEED_LIMIT)) begin
            state_nxt = ST_FAULT;
          end else if (seed_tie) begin
            state_nxt = ST_FAIL;
          end else begin
            state_nxt = ST_GOOD;
          end
        end
      end
      ST_GOOD, ST_FAIL, ST_FAULT: begin
        if (neg_cycle_start) begin
          state_nxt = ST_XCHG;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Link state fails on tie, fault or broken exchange; cleared by the next cycle
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      link_fail_r <= 1'b0;
    end else if (state_r == ST_XCHG && (state_nxt == ST_FAIL || state_nxt == ST_FAULT)) begin
      link_fail_r <= 1'b1;
    end else if (neg_cycle_start) begin
      link_fail_r <= 1'b0;
    end
  end
  assign copper_link_state = link_fail_r;
  assign restart_req       = link_fail_r && inhibit_expired;

  // Seed attempt counter
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      seed_cnt_r <= 4'h0;
    end else if (resolve_now && !seed_tie) begin
      seed_cnt_r <= 4'h0;
    end else if (seed_gen && seed_cnt_r != 4'hF) begin
      seed_cnt_r <= seed_cnt_r + 4'h1;
    end
  end

  // Fault flag: set wins over every clear
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      fault_r <= 1'b0;
    end else if (resolve_now && (forced_clash || (seed_tie && seed_cnt_r >= SEED_LIMIT))) begin
      fault_r <= 1'b1;
    end else if (resolve_now && !seed_tie) begin
      fault_r <= 1'b0;
    end else if (status_read || attach_reset || neg_enable_evt || neg_complete_evt) begin
      fault_r <= 1'b0;
    end
  end

  // Role held until the next negotiation cycle
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      role_r <= '0;
    end else if (neg_cycle_start) begin
      role_r.valid <= 1'b0;
    end else if (resolve_now && !seed_tie && !forced_clash) begin
      role_r.valid  <= 1'b1;
      role_r.leader <= loc_leads;
    end
  end
  assign role_result_indication = role_r;

endmodule : role_resolve

// ### rtl/role_res_pkg.sv
// Purpose: Shared constants and types for the lead/follow role resolution block
// Assumes: 32-bit register bus, one aligned word per register
// Notes:   Page layouts are those of the gigabit role exchange
package role_res_pkg;

  // Register byte offsets
  localparam logic [7:0]  CTRL_OFS      = 8'h00;
  localparam logic [7:0]  STATUS_OFS    = 8'h04;
  localparam logic [7:0]  SEED_OFS      = 8'h08;
  localparam logic [7:0]  ADV_OFS       = 8'h0C;
  localparam logic [7:0]  PARTNER_OFS   = 8'h10;

  // Control field positions
  localparam int          FORCE_EN_POS  = 0;
  localparam int          FORCE_VAL_POS = 1;
  localparam int          PORT_POS      = 2;
  localparam int          FULL_POS      = 3;
  localparam int          HALF_POS      = 4;
  localparam logic [4:0]  CTRL_RESET    = 5'h00;
  localparam logic [14:0] ADV_RESET     = 15'h0001;

  // Status field positions
  localparam int          FAULT_POS     = 15;
  localparam int          ROLE_POS      = 14;
  localparam int          VALID_POS     = 13;
  localparam int          LFAIL_POS     = 12;
  localparam int          SEQERR_POS    = 11;
  localparam int          CNT_POS       = 0;

  // Page contents
  localparam logic [10:0] MSG_CODE_ROLE = 11'h008;
  localparam logic [1:0]  PG_BASE       = 2'h0;
  localparam logic [1:0]  PG_MSG        = 2'h1;
  localparam logic [1:0]  PG_UNF1       = 2'h2;
  localparam logic [1:0]  PG_UNF2       = 2'h3;
  localparam logic [10:0] SEED_ALL_ONES = 11'h7FF;
  localparam logic [10:0] LFSR_RESET    = 11'h5A3;
  localparam logic [3:0]  SEED_LIMIT    = 4'h7;

  // Bus answers
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  typedef enum logic [4:0] {
    ST_IDLE  = 5'b00001,
    ST_XCHG  = 5'b00010,
    ST_GOOD  = 5'b00100,
    ST_FAIL  = 5'b01000,
    ST_FAULT = 5'b10000
  } res_state_e;

  typedef enum logic [1:0] {
    TY_SINGLE = 2'h0,
    TY_MULTI  = 2'h1,
    TY_FLEAD  = 2'h2,
    TY_FFOLL  = 2'h3
  } dev_type_e;

  typedef struct packed {
    logic        valid;
    logic [1:0]  idx;
    logic [15:0] bits;
  } page_s;

  typedef struct packed {
    logic valid;
    logic leader;
  } role_s;

endpackage : role_res_pkg

// ### tb/link_partner_model.sv
// Purpose: Link partner source of the four exchange pages
// Assumes: send pulses once per negotiation cycle
// Notes:   Idle bits toggle so stale pages never look valid
`timescale 1ns/10ps
module link_partner_model
  import role_res_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        send,
  input  wire logic [4:0]  unf1,
  input  wire logic [10:0] seed,
  output page_s            rx_page
);
  logic [2:0]  step_r = 3'h0;
  logic [15:0] last_r = 16'h0000;
  logic [15:0] pg;

  always_comb begin
    case (step_r)
      3'h1: pg = 16'h8001;
      3'h2: pg = 16'hB008;               // Ack2 set, must be ignored
      3'h3: pg = {5'h12, 6'h00, unf1};
      3'h4: pg = {5'h02, seed};
      default: pg = ~last_r;
    endcase
  end

  always @(posedge sys_clk) begin       // Pages back to back
    if (send)
      step_r <= 3'h1;
    else if (step_r == 3'h4)
      step_r <= 3'h0;
    else if (step_r != 3'h0)
      step_r <= step_r + 3'h1;
    last_r <= pg;
  end

  assign rx_page = {step_r != 3'h0, step_r[1:0] - 2'h1, pg};
endmodule : link_partner_model

// ### tb/role_resolve_assertions.sv
// Purpose: Port-level checks of page filling and role outcome
// Assumes: One clock, reset synchronous active high
// Notes:   Bound into role_resolve below
`timescale 1ns/10ps
module role_resolve_chk
  import role_res_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        reset,
  input wire logic        neg_cycle_start,
  input wire logic        pulse_link_good_check_state,
  input wire logic        highest_common_technology,
  input wire logic        inhibit_expired,
  input wire logic [1:0]  tx_page_sel,
  input wire logic [15:0] tx_page,
  input wire logic        copper_link_state,
  input wire logic        restart_req,
  input wire role_s       role_result_indication
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  chk_base_next: assert property (!$past(reset) && $past(tx_page_sel) == PG_BASE |-> tx_page[15])
    else $error("base page next bit low");
  chk_msg_code: assert property (!$past(reset) && $past(tx_page_sel) == PG_MSG |-> tx_page[10:0] == MSG_CODE_ROLE)
    else $error("message code wrong");
  chk_unf_upper: assert property (!$past(reset) && $past(tx_page_sel) == PG_UNF1 |-> tx_page[10:5] == 6'h00)
    else $error("page one upper bits set");
  chk_role_cause: assert property ($rose(role_result_indication.valid) |-> $past(pulse_link_good_check_state && highest_common_technology))
    else $error("role without good check");
  chk_skip_pass: assert property (pulse_link_good_check_state && !highest_common_technology && !copper_link_state
      |=> !copper_link_state && $stable(role_result_indication))
    else $error("resolution ran off gigabit");
  chk_role_hold: assert property (role_result_indication.valid && !neg_cycle_start |=> $stable(role_result_indication))
    else $error("role moved mid cycle");
  chk_role_drop: assert property (neg_cycle_start |=> !role_result_indication.valid)
    else $error("role kept into new cycle");
  chk_fail_hold: assert property (copper_link_state && !neg_cycle_start |=> copper_link_state)
    else $error("link fail dropped early");
  chk_restart_gate: assert property (restart_req == (copper_link_state && inhibit_expired))
    else $error("restart not gated by inhibit");
  chk_role_excl: assert property (role_result_indication.valid |-> !copper_link_state)
    else $error("role valid with link fail");

  cover property ($rose(role_result_indication.valid) && role_result_indication.leader);
  cover property ($rose(role_result_indication.valid) && !role_result_indication.leader);
  cover property ($rose(restart_req));
endmodule : role_resolve_chk

bind role_resolve role_resolve_chk role_resolve_chk_i (
  .sys_clk(sys_clk), .reset(reset), .neg_cycle_start(neg_cycle_start),
  .pulse_link_good_check_state(pulse_link_good_check_state),
  .highest_common_technology(highest_common_technology), .inhibit_expired(inhibit_expired),
  .tx_page_sel(tx_page_sel), .tx_page(tx_page), .copper_link_state(copper_link_state),
  .restart_req(restart_req), .role_result_indication(role_result_indication));

// ### tb/tb_top.sv
// Purpose: Self-checking bench for role_resolve
// Assumes: Partner pages follow each cycle start except in the no-page check
// Notes:   Seed ties replay the local seed read back
`timescale 1ns/10ps
module tb_top
  import role_res_pkg::*;
;
  logic        sys_clk, reset, awv, wv, brdy, arv, rrdy, awrdy, wrdy, bv, arrdy, rv;
  logic [7:0]  awa, ara;
  logic [31:0] wd, rdat, d;
  logic [1:0]  bresp, rresp, sel, r;
  logic        ncs, good, hct, inh, en_e, cp_e, ar_e, send, cls, rq;
  logic [4:0]  punf;
  logic [10:0] pseed, lseed, old;
  logic [15:0] txp;
  logic [3:0]  ev;
  logic [63:0] pe;
  page_s       rxp;
  role_s       role;
  int          fails, n_compared;
  logic [6:0]  tbl [12] = '{7'h08, 7'h06, 7'h16, 7'h18, 7'h46, 7'h10,
                             7'h41, 7'h43, 7'h33, 7'h31, 7'h03, 7'h39};

  role_resolve role_resolve_i (
    .sys_clk(sys_clk), .reset(reset), .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awrdy),
    .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_bresp(bresp),
    .s_axi_bvalid(bv), .s_axi_bready(brdy), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arrdy), .s_axi_rdata(rdat), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
    .s_axi_rready(rrdy), .neg_cycle_start(ncs), .pulse_link_good_check_state(good),
    .highest_common_technology(hct), .inhibit_expired(inh), .neg_enable_evt(en_e),
    .neg_complete_evt(cp_e), .attach_reset(ar_e), .tx_page_sel(sel), .tx_page(txp), .rx_page(rxp),
    .copper_link_state(cls), .restart_req(rq), .role_result_indication(role));

  link_partner_model link_partner_model_i (
    .sys_clk(sys_clk), .send(send), .unf1(punf), .seed(pseed), .rx_page(rxp));

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  initial begin
    #400000;
    fails++;
    complete_run();
  end

  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : complete_run

  task automatic cw(input string n, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : cw

  task automatic wr(input logic [7:0] a, input logic [31:0] x);
    awa <= a;
    wd <= x;
    awv <= 1'b1;
    wv <= 1'b1;
    brdy <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (awrdy) awv <= 1'b0;
      if (wrdy) wv <= 1'b0;
    end while (!bv);
    r = bresp;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    ara <= a;
    arv <= 1'b1;
    rrdy <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (arrdy) arv <= 1'b0;
    end while (!rv);
    d = rdat;
    r = rresp;
  endtask : rd

  task automatic cst(input logic [31:0] e, input logic [31:0] m);
    rd(STATUS_OFS);
    cw("status", e & m, d & m);
  endtask : cst

  // Cycle start, seed read back, partner pages, then good check
  task automatic neg(input logic [2:0] loc, input logic [4:0] rem, input logic [10:0] x, input logic h);
    wr(CTRL_OFS, {27'h0, 2'b11, loc});
    ncs <= 1'b1;
    @(posedge sys_clk);
    ncs <= 1'b0;
    rd(SEED_OFS);
    lseed = d[10:0];
    pseed <= lseed ^ x;
    punf <= rem;
    hct <= h;
    send <= 1'b1;
    @(posedge sys_clk);
    send <= 1'b0;
    repeat (5) @(posedge sys_clk);
    good <= 1'b1;
    @(posedge sys_clk);
    good <= 1'b0;
    // Read in the edge's own step: values are the ones the previous edge left
    @(posedge sys_clk);
  endtask : neg

  task automatic res(input logic v, input logic l, input logic f);
    cw("role valid", v, role.valid);
    if (v) cw("role leader", l, role.leader);
    cw("link fail", f, cls);
  endtask : res

  initial begin
    {awv, wv, brdy, arv, rrdy, ncs, good, inh, en_e, cp_e, ar_e, send} = '0;
    {awa, ara, wd, sel, punf, pseed} = '0;
    hct = 1'b1;
    fails = 0;
    n_compared = 0;
    reset = 1'b1;
    repeat (3) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    rd(CTRL_OFS);
    cw("ctrl reset", {27'h0, CTRL_RESET}, d);
    rd(ADV_OFS);
    cw("adv reset", {17'h0, ADV_RESET}, d);
    cst(32'h0000_0001, 32'h0000_B80F);
    rd(8'h14);
    cw("unmapped read", RESP_SLVERR, r);
    wr(STATUS_OFS, 32'h0000_FFFF);
    cw("read-only write", RESP_SLVERR, r);
    $display("reset and bus test done");
    wr(CTRL_OFS, 32'h0000_001E);
    wr(ADV_OFS, 32'h0000_02A5);
    rd(SEED_OFS);
    pe = {5'h00, d[10:0], 16'h001E, 16'h0008, 16'h82A5};
    for (int i = 0; i < 4; i++) begin
      sel <= i[1:0];
      repeat (2) @(posedge sys_clk);
      cw("tx page", pe[i*16 +: 16], txp);
    end
    $display("page fill test done");
    for (int i = 0; i < 12; i++) begin
      neg(tbl[i][6:4], {2'b11, tbl[i][3:1]}, 11'h400, 1'b1);
      res(1'b1, tbl[i][0], 1'b0);
      cst({17'h0, tbl[i][0], 14'h2000}, 32'h0000_F80F);
    end
    for (int i = 0; i < 2; i++) begin
      neg(i ? 3'b100 : 3'b000, i ? 5'h1C : 5'h18, i ? 11'h001 : 11'h400, 1'b1);
      res(1'b1, i ? lseed[0] : lseed[10], 1'b0);
    end
    // Good check with no pages received must fail the link
    ncs <= 1'b1;
    @(posedge sys_clk);
    ncs <= 1'b0;
    good <= 1'b1;
    @(posedge sys_clk);
    good <= 1'b0;
    @(posedge sys_clk);
    res(1'b0, 1'b0, 1'b1);
    neg(3'b000, 5'h18, 11'h000, 1'b0);
    res(1'b0, 1'b0, 1'b0);
    rd(PARTNER_OFS);
    cw("partner pages", {5'h00, pseed, 5'h12, 6'h00, punf}, d);
    $display("resolution test done");
    for (int j = 0; j < 4; j++) begin
      neg(j[0] ? 3'b001 : 3'b011, j[0] ? 5'h19 : 5'h1B, 11'h400, 1'b1);
      res(1'b0, 1'b0, 1'b1);
      ev = 4'h1 << j;
      inh <= 1'b1;
      {ar_e, cp_e, en_e} <= ev[3:1];
      @(posedge sys_clk);
      {ar_e, cp_e, en_e} <= 3'h0;
      cw("restart", 1'b1, rq);
      inh <= 1'b0;
      cst(j ? 32'h1000 : 32'h9000, 32'h0000_B000);
      if (j == 0) cst(32'h1000, 32'h0000_B000);
    end
    $display("fault test done");
    neg(3'b000, 5'h18, 11'h400, 1'b1);
    for (int k = 0; k < 8; k++) begin
      old = lseed;
      neg(3'b000, 5'h18, 11'h000, 1'b1);
      res(1'b0, 1'b0, 1'b1);
      cst({16'h0, k == 7, 3'b001, 8'h00, k[3:0]}, 32'h0000_B80F);
      if (k > 0) cw("new seed", 1'b1, lseed != old);
    end
    neg(3'b000, 5'h18, 11'h400, 1'b1);
    cst(32'h2000, 32'h0000_B80F);
    $display("seed retry test done");
    complete_run();
  end
endmodule : tb_top
